/* File: src/tmr_pkg.sv */
package tmr_pkg;
    localparam int ADDR_W = 2;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PRE_W = 3;
    // register offsets
    localparam logic [1:0] OFS_CTRL = 2'h0;
    localparam logic [1:0] OFS_CNT_LO = 2'h1;
    localparam logic [1:0] OFS_CNT_HI = 2'h2;
    localparam logic [1:0] OFS_PINS = 2'h3;
    // timer_c_control fields
    localparam int CTL_CCP_HI = 6;
    localparam int CTL_PS_HI = 5;
    localparam int CTL_PS_LO = 4;
    localparam int CTL_CCP_LO = 3;
    localparam int CTL_SYNC_BYP = 2;
    localparam int CTL_CLK_SRC = 1;
    localparam int CTL_RUN = 0;
    localparam logic [7:0] CTL_RST = 8'h00;
    localparam logic [7:0] CTL_WMASK = 8'h7F;
    // pin control fields
    localparam int PIN_DIR_OUT = 0;
    localparam int PIN_DIR_IN = 1;
    localparam int PIN_DAT_OUT = 2;
    localparam int PIN_DAT_IN = 3;
    localparam int PIN_OSC_EN = 4;
    localparam logic [7:0] PIN_RST = 8'h03;
    localparam logic [7:0] PIN_WMASK = 8'h1F;
    // prescale codes
    localparam logic [1:0] PS_DIV1 = 2'h0;
    localparam logic [1:0] PS_DIV2 = 2'h1;
    localparam logic [1:0] PS_DIV4 = 2'h2;
    localparam logic [1:0] PS_DIV8 = 2'h3;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_MAX = 16'hFFFF;
    localparam logic [2:0] PRE_ZERO = 3'h0;
    // prescaler terminal values
    localparam logic [2:0] PRE_MAX_DIV8 = 3'h7;
    localparam logic [2:0] PRE_MAX_DIV4 = 3'h3;
    localparam logic [2:0] PRE_MAX_DIV2 = 3'h1;
endpackage

/* File: src/edge_sync.sv */
module edge_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // raw input and edges
    input wire logic din,
    output logic rise_sync,
    output logic fall_sync,
    output logic rise_raw,
    output logic fall_raw
);
    logic meta_r;
    logic stab_r;
    logic stab_prev_r;
    logic raw_prev_r;

    // meta_r feeds only stab_r
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_r <= 1'b0;
            stab_r <= 1'b0;
            stab_prev_r <= 1'b0;
            raw_prev_r <= 1'b0;
        end else begin
            meta_r <= din;
            stab_r <= meta_r;
            stab_prev_r <= stab_r;
            raw_prev_r <= din;
        end
    end

    assign rise_sync = stab_r & ~stab_prev_r;
    assign fall_sync = ~stab_r & stab_prev_r;
    // bypass path: two cycles sooner, but trusts the pin to be clean
    assign rise_raw = din & ~raw_prev_r;
    assign fall_raw = ~din & raw_prev_r;
endmodule

/* File: src/main_counter.sv */
module main_counter (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register port
    input wire logic [tmr_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [tmr_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [tmr_pkg::DATA_W-1:0] reg_rdata,
    // capture/compare unit
    input wire logic special_event_trig,
    output logic ch1_uses_main,
    output logic ch2_uses_main,
    // count and overflow
    output logic [tmr_pkg::CNT_W-1:0] count_value,
    output logic overflow_pulse,
    // oscillator pins
    input wire logic osc_in_pin_i,
    output logic osc_in_pin_o,
    output logic osc_in_pin_oe,
    input wire logic osc_out_pin_i,
    output logic osc_out_pin_o,
    output logic osc_out_pin_oe
);
    import tmr_pkg::*;

    logic [7:0] ctrl_r;
    logic [7:0] pins_r;
    logic [CNT_W-1:0] cnt_r;
    logic [CNT_W-1:0] cnt_nxt;
    logic [PRE_W-1:0] pre_r;
    logic [PRE_W-1:0] pre_nxt;
    logic armed_r;
    logic [DATA_W-1:0] rdata_r;
    logic ovf_r;
    logic ch1_r;
    logic ch2_r;
    logic in_oe_r;
    logic out_oe_r;
    logic in_o_r;
    logic out_o_r;

    // decode
    wire ctrl_wr = reg_wr && (reg_addr == OFS_CTRL);
    wire lo_wr = reg_wr && (reg_addr == OFS_CNT_LO);
    wire hi_wr = reg_wr && (reg_addr == OFS_CNT_HI);
    wire pins_wr = reg_wr && (reg_addr == OFS_PINS);
    wire cnt_wr = lo_wr || hi_wr;

    wire run = ctrl_r[CTL_RUN];
    wire ext_sel = ctrl_r[CTL_CLK_SRC];
    wire sync_byp = ctrl_r[CTL_SYNC_BYP];
    wire [1:0] ps_sel = ctrl_r[CTL_PS_HI:CTL_PS_LO];
    wire osc_en = pins_r[PIN_OSC_EN];

    // oscillator takes over from the shared external pin when enabled
    wire ext_src = osc_en ? osc_in_pin_i : osc_out_pin_i;

    wire r_sync;
    wire f_sync;
    wire r_raw;
    wire f_raw;

    edge_sync u_edge (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .din(ext_src),
        .rise_sync(r_sync),
        .fall_sync(f_sync),
        .rise_raw(r_raw),
        .fall_raw(f_raw)
    );

    // sync bit only matters while the external clock is selected
    wire ext_rise = sync_byp ? r_raw : r_sync;
    wire ext_fall = sync_byp ? f_raw : f_sync;

    // an edge counts only after a falling edge has been seen
    wire src_tick = ext_sel ? (armed_r && ext_rise) : 1'b1;

    // prescale terminal value
    wire [PRE_W-1:0] pre_max = (ps_sel == PS_DIV8) ? PRE_MAX_DIV8 :
                               (ps_sel == PS_DIV4) ? PRE_MAX_DIV4 :
                               (ps_sel == PS_DIV2) ? PRE_MAX_DIV2 : PRE_ZERO;

    wire pre_tick = run && src_tick;
    wire inc = pre_tick && (pre_r == pre_max);
    wire wrap = inc && (cnt_r == CNT_MAX);

    // trigger works in the async mode too, but may race the pin there
    wire trig_clr = special_event_trig && !cnt_wr;

    // read mux
    wire [DATA_W-1:0] rd_mux = (reg_addr == OFS_CTRL) ? (ctrl_r & CTL_WMASK) :
                               (reg_addr == OFS_CNT_LO) ? cnt_r[7:0] :
                               (reg_addr == OFS_CNT_HI) ? cnt_r[15:8] :
                               (pins_r & PIN_WMASK);

    always_comb begin
        cnt_nxt = cnt_r;
        if (cnt_wr) begin
            if (lo_wr) begin
                cnt_nxt[7:0] = reg_wdata;
            end
            if (hi_wr) begin
                cnt_nxt[15:8] = reg_wdata;
            end
        end else if (trig_clr) begin
            cnt_nxt = CNT_ZERO;
        end else if (inc) begin
            cnt_nxt = cnt_r + 16'h0001;
        end
    end

    always_comb begin
        pre_nxt = pre_r;
        if (ctrl_wr) begin
            pre_nxt = PRE_ZERO;
        end else if (pre_tick) begin
            pre_nxt = (pre_r == pre_max) ? PRE_ZERO : pre_r + 3'h1;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_r <= CTL_RST;
            pins_r <= PIN_RST;
        end else begin
            if (ctrl_wr) begin
                ctrl_r <= reg_wdata & CTL_WMASK;
            end
            if (pins_wr) begin
                pins_r <= reg_wdata & PIN_WMASK;
            end
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_r <= CNT_ZERO;
            pre_r <= PRE_ZERO;
        end else begin
            cnt_r <= cnt_nxt;
            pre_r <= pre_nxt;
        end
    end

    // rearm after a stop or a source change
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            armed_r <= 1'b0;
        end else if (!run || !ext_sel) begin
            armed_r <= 1'b0;
        end else if (ext_fall) begin
            armed_r <= 1'b1;
        end
    end

    // trigger clear never reports an overflow
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_r <= 1'b0;
        end else begin
            ovf_r <= wrap && !cnt_wr && !special_event_trig;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= reg_rd ? rd_mux : '0;
        end
    end

    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ch1_r <= 1'b0;
            ch2_r <= 1'b0;
        end else begin
            ch1_r <= ctrl_r[CTL_CCP_HI];
            ch2_r <= ctrl_r[CTL_CCP_HI] | ctrl_r[CTL_CCP_LO];
        end
    end

    // direction bit set means input; oscillator forces both to inputs
    always_ff @(posedge core_clk or posedge sys_rst) begin
        if (sys_rst) begin
            in_oe_r <= 1'b0;
            out_oe_r <= 1'b0;
            in_o_r <= 1'b0;
            out_o_r <= 1'b0;
        end else begin
            in_oe_r <= !osc_en && !pins_r[PIN_DIR_IN];
            out_oe_r <= !osc_en && !pins_r[PIN_DIR_OUT];
            in_o_r <= pins_r[PIN_DAT_IN];
            out_o_r <= pins_r[PIN_DAT_OUT];
        end
    end

    assign reg_rdata = rdata_r;
    assign count_value = cnt_r;
    assign overflow_pulse = ovf_r;
    assign ch1_uses_main = ch1_r;
    assign ch2_uses_main = ch2_r;
    assign osc_in_pin_oe = in_oe_r;
    assign osc_out_pin_oe = out_oe_r;
    assign osc_in_pin_o = in_o_r;
    assign osc_out_pin_o = out_o_r;

    chk_ccp_select: assert property (@(posedge core_clk) disable iff (sys_rst)
        1'b1 |=> (ch1_uses_main == $past(ctrl_r[CTL_CCP_HI]))
            && (ch2_uses_main == ($past(ctrl_r[CTL_CCP_HI]) | $past(ctrl_r[CTL_CCP_LO]))))
        else $error("capture time base select wrong");

    chk_div8_spacing: assert property (@(posedge core_clk)
        disable iff (sys_rst || ctrl_wr)
        (inc && ps_sel == PS_DIV8) |=> !inc [*7])
        else $error("divide by eight counted too soon");

    chk_timer_div1: assert property (@(posedge core_clk) disable iff (sys_rst)
        (run && !ext_sel && ps_sel == PS_DIV1 && !cnt_wr && !special_event_trig && !ctrl_wr)
        |=> (count_value == $past(count_value) + 16'h0001))
        else $error("timer did not count each cycle");

    chk_ext_gated: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ext_sel && !ext_rise && !cnt_wr && !special_event_trig) |=> $stable(count_value))
        else $error("counter moved without an input edge");

    chk_osc_inputs: assert property (@(posedge core_clk) disable iff (sys_rst)
        osc_en |=> (!osc_in_pin_oe && !osc_out_pin_oe))
        else $error("oscillator pin driven while oscillator on");

    chk_trig_clear: assert property (@(posedge core_clk) disable iff (sys_rst)
        (special_event_trig && !cnt_wr) |=> (count_value == CNT_ZERO) && !overflow_pulse)
        else $error("trigger did not clear count");

    chk_write_wins: assert property (@(posedge core_clk) disable iff (sys_rst)
        (special_event_trig && lo_wr) |=> (count_value[7:0] == $past(reg_wdata))
            && (count_value[15:8] == $past(count_value[15:8])))
        else $error("count write lost to trigger");

    chk_stopped_hold: assert property (@(posedge core_clk) disable iff (sys_rst)
        (!run && !cnt_wr && !special_event_trig) ##1 (!run && !cnt_wr && !special_event_trig)
        |-> $stable(count_value))
        else $error("counter moved while stopped");

    chk_sync_delay: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ext_sel && !sync_byp && r_sync) |-> $past(ext_src, 2) && !$past(ext_src, 3))
        else $error("synchronised edge not two cycles late");

    chk_div4_spacing: assert property (@(posedge core_clk)
        disable iff (sys_rst || ctrl_wr)
        (inc && ps_sel == PS_DIV4) |=> !inc [*3])
        else $error("divide by four counted too soon");

    chk_div2_spacing: assert property (@(posedge core_clk)
        disable iff (sys_rst || ctrl_wr)
        (inc && ps_sel == PS_DIV2) |=> !inc)
        else $error("divide by two counted too soon");

    chk_ctrl_clears_pre: assert property (@(posedge core_clk) disable iff (sys_rst)
        ctrl_wr |=> (pre_r == PRE_ZERO))
        else $error("prescaler not cleared by control write");

    chk_reset_idle: assert property (@(posedge core_clk) disable iff (sys_rst)
        $past(sys_rst) |-> (!run && (count_value == CNT_ZERO)))
        else $error("counter not idle after reset");

    chk_first_fall: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ext_sel && !armed_r && !cnt_wr && !special_event_trig) |=> $stable(count_value))
        else $error("counted before the first falling edge");

    chk_bypass_edge: assert property (@(posedge core_clk) disable iff (sys_rst)
        (ext_sel && sync_byp && r_raw) |-> (ext_src && !$past(ext_src)))
        else $error("bypassed edge not taken straight from the pin");

    chk_trig_no_ovf: assert property (@(posedge core_clk) disable iff (sys_rst)
        special_event_trig |=> !overflow_pulse)
        else $error("trigger raised the overflow pulse");

    chk_both_channels: assert property (@(posedge core_clk) disable iff (sys_rst)
        ch1_uses_main |-> ch2_uses_main)
        else $error("channel one served alone");

    chk_pin_direction: assert property (@(posedge core_clk) disable iff (sys_rst)
        !osc_en |=> (osc_in_pin_oe == !$past(pins_r[PIN_DIR_IN]))
            && (osc_out_pin_oe == !$past(pins_r[PIN_DIR_OUT])))
        else $error("pin drive does not follow direction bits");
endmodule

/* File: testbench/ext_clock_src.sv */
module ext_clock_src (
    // levels presented at the two oscillator pins
    output logic osc_level,
    output logic pin_level
);
    timeunit 1ns;
    timeprecision 1ns;
    // idle high between bursts, so each burst opens with a falling edge
    initial begin
        osc_level = 1'b1;
        pin_level = 1'b1;
    end
    // delays in ns keep the edges out of phase with the core clock
    task automatic burst(input bit to_osc, input int n, input int half_ns);
        for (int i = 0; i < n; i++) begin
            #(half_ns);
            if (to_osc) osc_level = 1'b0; else pin_level = 1'b0;
            #(half_ns);
            if (to_osc) osc_level = 1'b1; else pin_level = 1'b1;
        end
    endtask
endmodule

/* File: testbench/sixteen_bit_timer_counter_tb.sv */
module sixteen_bit_timer_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import tmr_pkg::*;
    logic core_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [ADDR_W-1:0] reg_addr = '0;
    logic [DATA_W-1:0] reg_wdata = '0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [DATA_W-1:0] reg_rdata;
    logic special_event_trig = 1'b0;
    logic ch1_uses_main, ch2_uses_main, overflow_pulse;
    logic [CNT_W-1:0] count_value;
    logic osc_in_pin_o, osc_in_pin_oe, osc_out_pin_o, osc_out_pin_oe;
    logic osc_level, pin_level;
    wire logic osc_in_w = osc_in_pin_oe ? osc_in_pin_o : osc_level;
    wire logic osc_out_w = osc_out_pin_oe ? osc_out_pin_o : pin_level;
    int n_errors = 0;
    int check_count = 0;
    logic [7:0] d;
    logic [15:0] a;
    int k;

    main_counter dut_u (.core_clk(core_clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .special_event_trig(special_event_trig), .ch1_uses_main(ch1_uses_main),
        .ch2_uses_main(ch2_uses_main), .count_value(count_value),
        .overflow_pulse(overflow_pulse), .osc_in_pin_i(osc_in_w),
        .osc_in_pin_o(osc_in_pin_o), .osc_in_pin_oe(osc_in_pin_oe),
        .osc_out_pin_i(osc_out_w), .osc_out_pin_o(osc_out_pin_o),
        .osc_out_pin_oe(osc_out_pin_oe));
    ext_clock_src src_u (.osc_level(osc_level), .pin_level(pin_level));

    initial begin
        forever #50 core_clk = ~core_clk;
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            $display("BAD %s expected %h seen %h", what, exp, got);
            n_errors++;
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic wr(input logic [1:0] ad, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask

    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [1:0] ad, output logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= ad;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask

    task automatic setcnt(input logic [15:0] v);
        wr(OFS_CNT_LO, v[7:0]);
        wr(OFS_CNT_HI, v[15:8]);
    endtask

    task automatic trig(input logic wr_too, input logic [7:0] lo);
        @(posedge core_clk);
        special_event_trig <= 1'b1;
        reg_addr <= OFS_CNT_LO;
        reg_wdata <= lo;
        reg_wr <= wr_too;
        @(posedge core_clk);
        special_event_trig <= 1'b0;
        reg_wr <= 1'b0;
        #1;
    endtask

    task automatic t_reset();
        rd(OFS_CTRL, d);
        chk("ctrl reset", 16'(CTL_RST), 16'(d));
        rd(OFS_PINS, d);
        chk("pin reset", 16'(PIN_RST), 16'(d));
        cyc(10);
        chk("idle count", CNT_ZERO, count_value);
        chk("reset oe", 16'h0000, 16'({osc_in_pin_oe, osc_out_pin_oe}));
    endtask

    task automatic t_source();
        logic [1:0] c;
        wr(OFS_CTRL, 8'hFF);
        rd(OFS_CTRL, d);
        chk("ctrl readback", 16'(CTL_WMASK), 16'(d));
        for (int i = 0; i < 4; i++) begin
            c = i[1:0];
            wr(OFS_CTRL, {1'b0, c[1], 2'b00, c[0], 3'b000});
            cyc(2);
            chk("ch select", 16'({c[1], c[1] | c[0]}), 16'({ch1_uses_main, ch2_uses_main}));
        end
    endtask

    task automatic t_prescale();
        logic [1:0] ps;
        setcnt(CNT_ZERO);
        for (int i = 0; i < 4; i++) begin
            ps = i[1:0];
            // bypass bit set on the last code: it must not matter on the internal clock
            wr(OFS_CTRL, {2'b00, ps, 1'b0, ps == PS_DIV8, 2'b01});
            cyc(5);
            a = count_value;
            cyc(32);
            chk("timer rate", 16'(32 >> i), count_value - a);
        end
        wr(OFS_CTRL, 8'h00);
        cyc(2);
        a = count_value;
        cyc(20);
        chk("stopped", a, count_value);
    endtask

    task automatic t_pins();
        wr(OFS_PINS, 8'h0C);
        cyc(2);
        chk("pin drive", 16'h000F, 16'({osc_in_pin_oe, osc_out_pin_oe, osc_in_pin_o, osc_out_pin_o}));
        wr(OFS_PINS, 8'h1C);
        cyc(2);
        chk("osc oe", 16'h0000, 16'({osc_in_pin_oe, osc_out_pin_oe}));
        wr(OFS_PINS, PIN_RST);
    endtask

    task automatic t_external();
        for (int s = 0; s < 2; s++) begin
            setcnt(CNT_ZERO);
            wr(OFS_CTRL, {5'b00000, s[0], 2'b11});
            cyc(3);
            src_u.burst(1'b0, 5, 350);
            cyc(6);
            chk("pin count", 16'h0005, count_value);
        end
        wr(OFS_PINS, 8'h10);
        setcnt(CNT_ZERO);
        wr(OFS_CTRL, 8'h03);
        cyc(3);
        src_u.burst(1'b0, 3, 350);
        src_u.burst(1'b1, 4, 350);
        cyc(6);
        chk("osc count", 16'h0004, count_value);
        // prescale applies to the external source as well
        setcnt(CNT_ZERO);
        wr(OFS_CTRL, 8'h13);
        cyc(3);
        src_u.burst(1'b1, 6, 350);
        cyc(6);
        chk("osc div2", 16'h0003, count_value);
    endtask

    task automatic t_trigger();
        wr(OFS_CTRL, 8'h00);
        setcnt(CNT_MAX);
        trig(1'b0, 8'h00);
        chk("trig clear", CNT_ZERO, count_value);
        // running: the trigger lands while the count stands at FFFF, so a wrap is due
        setcnt(16'hFFFE);
        wr(OFS_CTRL, 8'h01);
        trig(1'b0, 8'h00);
        chk("trig no ovf", 16'h0000, 16'(overflow_pulse));
        cyc(1);
        chk("trig no ovf late", 16'h0000, 16'(overflow_pulse));
        wr(OFS_CTRL, 8'h00);
        setcnt(16'h1234);
        trig(1'b1, 8'h77);
        chk("write wins", 16'h1277, count_value);
        rd(OFS_CNT_LO, d);
        chk("count low read", 16'h0077, 16'(d));
        rd(OFS_CNT_HI, d);
        chk("count high read", 16'h0012, 16'(d));
        setcnt(16'hFFFE);
        wr(OFS_CTRL, 8'h01);
        k = 0;
        while (overflow_pulse !== 1'b1 && k < 20) begin
            cyc(1);
            k++;
        end
        chk("count overflow", 16'h0001, 16'(overflow_pulse));
    endtask

    initial begin
        repeat (20) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset();
        t_source();
        t_prescale();
        t_pins();
        t_external();
        t_trigger();
        // second reset with the counter running: it must come back idle
        @(posedge core_clk);
        sys_rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        sys_rst <= 1'b0;
        cyc(1);
        t_reset();
        conclude();
    end

    // a hang counts as a mismatch
    initial begin
        #3000000;
        n_errors++;
        conclude();
    end
endmodule
